// ==== design/spc_cfg.svh ====
// Constants for the sine PWM commutation controller
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH
// Clock rates
`define SPC_PCLK_HZ 250000000
`define SPC_FOSC_HZ 5000000
`define SPC_LOCK_OSC_HZ 2000
// Carrier: 252 reference cycles per period
`define SPC_CAR_PERIOD 252
`define SPC_CAR_LAST 8'd251
`define SPC_CAR_HALF 8'd126
// Lock timer: 1024 oscillator cycles
`define SPC_LOCK_CYCLES 1024
`define SPC_LOCK_LAST 10'd1023
// 60-degree interval limit at 2.5 Hz, reference cycles (2^13 * 41)
`define SPC_SLOW_CYC (8192 * 41)
// Modulated waveform layout
`define SPC_PTS_SHIFT 5
`define SPC_PT_LAST 5'd31
`define SPC_SEG_LAST 3'd5
`define SPC_SEG_NONE 3'd7
`define SPC_ANG_FULL 10'd384
`define SPC_ANG_TWO 10'd768
`define SPC_ANG_HALF 9'd192
`define SPC_ANG_V 10'd128
`define SPC_ANG_W 10'd256
`define SPC_SIN_MID 7'd63
`define SPC_SIN_GAIN 20'd55
`define SPC_SIN_SHIFT 13
// Register offsets
`define SPC_CTRL_OFS 12'h000
`define SPC_STAT_OFS 12'h004
`define SPC_PER_OFS 12'h008
// Control fields and reset
`define SPC_CTRL_DIR 0
`define SPC_CTRL_RST 1
`define SPC_CTRL_LA_LO 2
`define SPC_CTRL_LA_HI 6
`define SPC_CTRL_INIT 32'h0000_0000
`endif

// ==== design/spc_pkg.sv ====
// Types for the sine PWM commutation controller
package spc_pkg;
   typedef enum logic [1:0] {LK_WATCH, LK_OFF, LK_ON, LK_LATCH} spc_lock_t;
endpackage : spc_pkg

// ==== design/spc_top.sv ====
// Commutation, sine PWM and protection logic of a three-phase motor driver
//
// Summary of operation
// [R01] Triangle carrier period is 252 reference clock cycles.
// [R02] Drive waveform leads Hall position by 0 to 29 electrical degrees.
// [R03] Three rotation pulses per electrical revolution.
// [R04] Direction detected once per electrical revolution; mode re-evaluated.
// [R05] 180 mode when direction matches select, else 120 mode.
// [R06] Below 2.5 Hz Hall frequency, 120 square wave is forced.
// [R07] Overcurrent turns outputs off; released at every carrier start.
// [R08] External reset high holds outputs off; low resumes.
// [R09] Hall all high or all low turns outputs off; retried per carrier.
// [R10] No move into 180 mode within lock time means locked, outputs off.
// [R11] Lock detect and off periods are both 1024 lock timer cycles.
// [R12] Restart select high: drive and off alternate one lock period each.
// [R13] Lock protection cancelled at 2.5 Hz with 180 mode reached.
// [R14] Restart select low: latch off until undervoltage or stop command.
// [R15] Outputs disabled while motor supply is out of range.
// [R16] Reference cycles between Hall edges measure each 60-degree interval.
// [R17] Each 60-degree segment is 32 points, each 1/32 of last interval.
// [R18] After 32 points without an edge, continue next segment same pace.
// [R19] Every Hall edge realigns the waveform, discarding a partial segment.
// [R20] Phase PWM compares modulated waveform with the carrier.
// [R21] Square 120 drive at start, sine PWM above fosc/(2^13*41*6).
// [R22] Speed command at stop level turns outputs off.
// [R23] Lead only at 2.5 Hz or more; zero in reverse 120 mode.
// [R24] All shutdown sources ORed to turn every phase off.
// [R25] Lead code has 32 steps of about 0.94 degrees.
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ns
`include "spc_cfg.svh"

module spc_top
   import spc_pkg::*;
#(
   parameter int REF_DIV = `SPC_PCLK_HZ / `SPC_FOSC_HZ,
   parameter int LOCK_DIV = `SPC_PCLK_HZ / `SPC_LOCK_OSC_HZ,
   parameter int SLOW_LIM = `SPC_SLOW_CYC
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Hall position inputs
   input wire logic hall_phase_u,
   input wire logic hall_phase_v,
   input wire logic hall_phase_w,
   // Comparator and protection inputs
   input wire logic current_sense_input,
   input wire logic ext_reset_in,
   input wire logic speed_command_input,
   input wire logic motor_supply_ok,
   // Phase drive and rotation pulse
   output logic [2:0] drive_high,
   output logic [2:0] drive_low,
   output logic rotation_pulse_out
);

   // ----------------------------------------
   // Functions
   // ----------------------------------------

   // Hall code to sector, illegal codes give none
   function automatic logic [2:0] spc_sector(input logic [2:0] h);
      case (h)
         3'b001: return 3'd0;
         3'b011: return 3'd1;
         3'b010: return 3'd2;
         3'b110: return 3'd3;
         3'b100: return 3'd4;
         3'b101: return 3'd5;
         default: return `SPC_SEG_NONE;
      endcase
   endfunction : spc_sector

   // Sector sum modulo six
   function automatic logic [2:0] spc_seg_add(input logic [2:0] a, input logic [2:0] b);
      logic [3:0] s;
      s = {1'b0, a} + {1'b0, b};
      return (s > {1'b0, `SPC_SEG_LAST}) ? 3'(s - 4'd6) : s[2:0];
   endfunction : spc_seg_add

   // Angle modulo one electrical turn
   function automatic logic [8:0] spc_wrap(input logic [9:0] v);
      if (v >= `SPC_ANG_TWO)
         return 9'(v - `SPC_ANG_TWO);
      if (v >= `SPC_ANG_FULL)
         return 9'(v - `SPC_ANG_FULL);
      return v[8:0];
   endfunction : spc_wrap

   // Parabolic sine, scaled onto the carrier range
   function automatic logic [6:0] spc_sine(input logic [8:0] a);
      logic [8:0] x;
      logic [15:0] s;
      logic [6:0] m;
      x = (a >= `SPC_ANG_HALF) ? a - `SPC_ANG_HALF : a;
      s = 16'(x) * 16'(`SPC_ANG_HALF - x);
      m = 7'((20'(s) * `SPC_SIN_GAIN) >> `SPC_SIN_SHIFT);
      return (a >= `SPC_ANG_HALF) ? `SPC_SIN_MID - m : `SPC_SIN_MID + m;
   endfunction : spc_sine

   // Square 120 pattern: high two sectors, float, low two, float
   function automatic logic [1:0] spc_square(input logic [2:0] seg);
      case (seg)
         3'd0, 3'd1: return 2'b10;
         3'd3, 3'd4: return 2'b01;
         default: return 2'b00;
      endcase
   endfunction : spc_square

   // ----------------------------------------
   // Registers and state
   // ----------------------------------------
   logic [31:0] ctrl;
   logic direction_select;
   logic lock_restart_select;
   logic [4:0] lead_angle_input;
   logic [15:0] ref_div_cnt;
   logic ref_tick;
   logic [16:0] lock_div_cnt;
   logic lock_tick;
   logic [7:0] car_cnt;
   logic car_start;
   logic [6:0] carrier;
   logic [2:0] hall_q;
   logic hall_armed;
   logic [2:0] hall_now;
   logic hall_edge;
   logic [2:0] new_sec;
   logic [2:0] old_sec;
   logic step_cw;
   logic det_ccw;
   logic [19:0] int_cnt;
   logic [19:0] period;
   logic slow;
   logic mode180;
   logic [14:0] step_len;
   logic [14:0] step_cnt;
   logic [4:0] point;
   logic [2:0] wave_seg;
   logic oc_latch;
   logic hall_fault;
   spc_lock_t lock_st;
   logic [9:0] lock_cnt;
   logic lock_off;
   logic off_all;
   logic [4:0] la_eff;
   logic [9:0] ang_u;
   logic [2:0] sq_v;
   logic [2:0] sq_w;
   logic [9:0] off_v;
   logic [9:0] off_w;
   logic [6:0] wave [3];
   logic [2:0] sq_seg [3];
   logic [2:0] next_high;
   logic [2:0] next_low;

   assign direction_select = ctrl[`SPC_CTRL_DIR];
   assign lock_restart_select = ctrl[`SPC_CTRL_RST];
   assign lead_angle_input = ctrl[`SPC_CTRL_LA_HI:`SPC_CTRL_LA_LO];

   // ----------------------------------------
   // APB slave, one wait state
   // ----------------------------------------

   // Answer once per access; pready low again between accesses
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= `SPC_CTRL_INIT;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else if (psel && penable && !pready)
      begin
         pready <= 1'b1;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         case (paddr)
            `SPC_CTRL_OFS:
            begin
               if (pwrite)
                  ctrl <= {25'h000_0000, pwdata[`SPC_CTRL_LA_HI:0]};
               else
                  prdata <= ctrl;
            end
            `SPC_STAT_OFS:
               if (!pwrite)
                  prdata <= {24'h00_0000, lock_st, det_ccw, off_all,
                             hall_fault, oc_latch, slow, mode180};
            `SPC_PER_OFS:
               if (!pwrite)
                  prdata <= {12'h000, period};
            default:
               pslverr <= 1'b1;
         endcase
      end
      else
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ----------------------------------------
   // Clock enables
   // ----------------------------------------

   // Reference clock and lock timer oscillator as enables
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ref_div_cnt <= 16'h0000;
         lock_div_cnt <= 17'h0_0000;
      end
      else
      begin
         ref_div_cnt <= ref_tick ? 16'h0000 : ref_div_cnt + 16'h0001;
         lock_div_cnt <= lock_tick ? 17'h0_0000 : lock_div_cnt + 17'h0_0001;
      end
   end
   assign ref_tick = (ref_div_cnt == 16'(REF_DIV - 1));
   assign lock_tick = (lock_div_cnt == 17'(LOCK_DIV - 1));

   // ----------------------------------------
   // Triangle carrier
   // ----------------------------------------

   // Count 0..251, fold into a 0..125 triangle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         car_cnt <= 8'h00;
      else if (ref_tick)
         car_cnt <= (car_cnt == `SPC_CAR_LAST) ? 8'h00 : car_cnt + 8'h01; // [R01]
   end
   assign car_start = ref_tick && (car_cnt == `SPC_CAR_LAST);
   assign carrier = (car_cnt < `SPC_CAR_HALF) ? car_cnt[6:0] : 7'(`SPC_CAR_LAST - car_cnt);

   // ----------------------------------------
   // Hall edges, direction, interval
   // ----------------------------------------
   assign hall_now = {hall_phase_u, hall_phase_v, hall_phase_w};
   assign hall_edge = hall_armed && (hall_now != hall_q); // No false edge on the first sample after reset
   assign new_sec = spc_sector(hall_now);
   assign step_cw = (new_sec == spc_seg_add(old_sec, 3'd1));

   // Edge bookkeeping; direction only refreshed on entry to sector zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hall_q <= 3'b000;
         hall_armed <= 1'b0;
         old_sec <= 3'd0;
         det_ccw <= 1'b0;
         rotation_pulse_out <= 1'b0;
      end
      else
      begin
         hall_q <= hall_now;
         hall_armed <= 1'b1;
         if (hall_edge && new_sec != `SPC_SEG_NONE)
         begin
            old_sec <= new_sec;
            rotation_pulse_out <= !rotation_pulse_out; // [R03]
            if (new_sec == 3'd0)
               det_ccw <= !step_cw; // [R04]
         end
      end
   end

   // Interval counter saturates, so a stalled motor reads as slow
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         int_cnt <= 20'h0_0000;
         period <= 20'h0_0000;
         slow <= 1'b1;
      end
      else if (hall_edge)
      begin
         int_cnt <= 20'h0_0000;
         period <= int_cnt; // [R16]
         slow <= (int_cnt >= 20'(SLOW_LIM)); // [R21]
      end
      else if (ref_tick && int_cnt < 20'(SLOW_LIM))
         int_cnt <= int_cnt + 20'h0_0001;
      else if (int_cnt >= 20'(SLOW_LIM))
         slow <= 1'b1;
   end

   // Mode choice: match gives 180, mismatch or slow gives 120
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mode180 <= 1'b0;
      else
         mode180 <= (det_ccw == direction_select) && !slow; // [R05] [R06]
   end

   // ----------------------------------------
   // Modulated waveform pacing
   // ----------------------------------------
   assign step_len = (period[19:`SPC_PTS_SHIFT] == 15'h0000) ? 15'h0001 : period[19:`SPC_PTS_SHIFT];

   // 32 points per segment, realigned on every edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         step_cnt <= 15'h0000;
         point <= 5'h00;
         wave_seg <= 3'd0;
      end
      else if (hall_edge)
      begin
         step_cnt <= 15'h0000; // [R19]
         point <= 5'h00;
         wave_seg <= (new_sec == `SPC_SEG_NONE) ? wave_seg : new_sec;
      end
      else if (ref_tick)
      begin
         if (step_cnt >= step_len - 15'h0001)
         begin
            step_cnt <= 15'h0000;
            point <= point + 5'h01; // [R17]
            if (point == `SPC_PT_LAST)
               wave_seg <= spc_seg_add(wave_seg, 3'd1); // [R18]
         end
         else
            step_cnt <= step_cnt + 15'h0001;
      end
   end

   // ----------------------------------------
   // Protection latches
   // ----------------------------------------

   // Set wins over the carrier-start release
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         oc_latch <= 1'b0;
         hall_fault <= 1'b0;
      end
      else
      begin
         if (current_sense_input)
            oc_latch <= 1'b1; // [R07]
         else if (car_start)
            oc_latch <= 1'b0; // [R07]
         if (new_sec == `SPC_SEG_NONE)
            hall_fault <= 1'b1; // [R09]
         else if (car_start)
            hall_fault <= 1'b0; // [R09]
      end
   end

   // ----------------------------------------
   // Lock detection
   // ----------------------------------------

   // Watch, then either alternate off and on or latch off
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lock_st <= LK_WATCH;
         lock_cnt <= 10'h000;
      end
      else
      begin
         unique case (lock_st)
            LK_WATCH:
               if (mode180)
                  lock_cnt <= 10'h000;
               else if (lock_tick)
               begin
                  lock_cnt <= lock_cnt + 10'h001;
                  if (lock_cnt == `SPC_LOCK_LAST) // [R11]
                     lock_st <= lock_restart_select ? LK_OFF : LK_LATCH; // [R10] [R12]
               end
            LK_OFF:
               if (lock_tick)
               begin
                  lock_cnt <= lock_cnt + 10'h001;
                  if (lock_cnt == `SPC_LOCK_LAST)
                     lock_st <= LK_ON; // [R11] [R12]
               end
            LK_ON:
               if (mode180)
               begin
                  lock_cnt <= 10'h000;
                  lock_st <= LK_WATCH; // [R13]
               end
               else if (lock_tick)
               begin
                  lock_cnt <= lock_cnt + 10'h001;
                  if (lock_cnt == `SPC_LOCK_LAST)
                     lock_st <= LK_OFF; // [R12]
               end
            LK_LATCH:
               if (!motor_supply_ok || !speed_command_input)
               begin
                  lock_cnt <= 10'h000;
                  lock_st <= LK_WATCH; // [R14]
               end
         endcase
      end
   end
   assign lock_off = (lock_st == LK_OFF) || (lock_st == LK_LATCH);

   // ----------------------------------------
   // Drive generation
   // ----------------------------------------

   // Every shutdown source forces all phases to float
   assign off_all = oc_latch || ext_reset_in || hall_fault || lock_off // [R24] [R08]
                 || !motor_supply_ok || !speed_command_input; // [R15] [R22]

   // Lead only in sine mode, so never in slow or reverse 120
   assign la_eff = mode180 ? lead_angle_input : 5'h00; // [R23] [R25]
   assign ang_u = {1'b0, wave_seg, 6'h00} + {4'h0, point, 1'b0} + {5'h00, la_eff}; // [R02]
   assign off_v = direction_select ? `SPC_ANG_W : `SPC_ANG_V;
   assign off_w = direction_select ? `SPC_ANG_V : `SPC_ANG_W;
   assign wave[0] = spc_sine(spc_wrap(ang_u));
   assign wave[1] = spc_sine(spc_wrap(ang_u + off_v));
   assign wave[2] = spc_sine(spc_wrap(ang_u + off_w));
   assign sq_v = direction_select ? 3'd4 : 3'd2;
   assign sq_w = direction_select ? 3'd2 : 3'd4;
   assign sq_seg[0] = old_sec;
   assign sq_seg[1] = spc_seg_add(old_sec, sq_v);
   assign sq_seg[2] = spc_seg_add(old_sec, sq_w);

   // Sine PWM compare in 180 mode, square pattern in 120 mode
   always_comb
   begin
      next_high = 3'b000;
      next_low = 3'b000;
      for (int p = 0; p < 3; p++)
      begin
         if (off_all)
         begin
            next_high[2 - p] = 1'b0;
            next_low[2 - p] = 1'b0;
         end
         else if (mode180)
         begin
            next_high[2 - p] = (wave[p] > carrier); // [R20]
            next_low[2 - p] = (wave[p] <= carrier);
         end
         else
            {next_high[2 - p], next_low[2 - p]} = spc_square(sq_seg[p]); // [R21]
      end
   end

   // Registered phase outputs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         drive_high <= 3'b000;
         drive_low <= 3'b000;
      end
      else
      begin
         drive_high <= next_high;
         drive_low <= next_low;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_car_wrap;
      ref_tick && car_cnt == `SPC_CAR_LAST;
   endsequence
   sequence s_all_off;
      drive_high == 3'b000 && drive_low == 3'b000;
   endsequence

   AST_CARRIER_WRAP: assert property (s_car_wrap |=> car_cnt == 8'h00) // [R01]
      else $error("carrier did not wrap after 252 counts");
   AST_OC_OFF: assert property (current_sense_input |=> ##1 s_all_off) // [R07]
      else $error("overcurrent did not turn outputs off");
   AST_OC_RELEASE: assert property (s_car_wrap and !current_sense_input |=> !oc_latch) // [R07]
      else $error("overcurrent latch not released at carrier start");
   AST_EXT_RESET: assert property (ext_reset_in |=> s_all_off) // [R08]
      else $error("external reset did not turn outputs off");
   AST_HALL_FAULT: assert property (hall_now == 3'b111 || hall_now == 3'b000 |=> ##1 s_all_off) // [R09]
      else $error("hall fault did not turn outputs off");
   AST_ROT_PULSE: assert property (hall_edge && new_sec != `SPC_SEG_NONE
      |=> rotation_pulse_out != $past(rotation_pulse_out)) // [R03]
      else $error("rotation pulse missed a hall edge");
   AST_SLOW_120: assert property (slow |=> !mode180) // [R06]
      else $error("sine mode while hall frequency is slow");
   AST_LOCK_HOLD: assert property (lock_st == LK_LATCH && motor_supply_ok && speed_command_input
      |=> lock_st == LK_LATCH ##0 s_all_off) // [R14]
      else $error("lock latch released without a clearing cause");
   AST_SUPPLY_OFF: assert property (!motor_supply_ok || !speed_command_input |=> s_all_off) // [R15]
      else $error("outputs driven with supply low or stop command");
   AST_REALIGN: assert property (hall_edge |=> point == 5'h00 && step_cnt == 15'h0000) // [R19]
      else $error("waveform not realigned at hall edge");

endmodule : spc_top

// ==== verification/spc_motor_model.sv ====
// Hall sensor and power stage model facing the commutation controller
`timescale 1ns/1ns
module spc_motor_model
(
   // Clock
   input wire logic pclk,
   // Motion control from the bench
   input wire logic run,
   input wire logic ccw,
   input wire logic fault,
   input wire logic [15:0] step_cyc,
   // Hall sensor levels
   output logic hall_u,
   output logic hall_v,
   output logic hall_w,
   // Power stage gate inputs
   input wire logic [2:0] drive_high,
   input wire logic [2:0] drive_low,
   output int shoot_cnt
);
   logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
   int pos = 0;
   int cnt = 0;
   int sc = 0;

   // One sector per step; a stalled rotor keeps showing its last position
   always @(posedge pclk)
   begin
      if (run && cnt + 1 >= int'(step_cyc))
      begin
         cnt <= 0;
         pos <= ccw ? (pos + 5) % 6 : (pos + 1) % 6;
      end
      else if (run)
         cnt <= cnt + 1;
   end

   // Broken sensor wiring reads all high
   assign {hall_u, hall_v, hall_w} = fault ? 3'h7 : seq[pos];

   // Both switches of a leg on would short the supply
   always @(posedge pclk)
   begin
      if ((drive_high & drive_low) != 3'h0)
         sc <= sc + 1;
   end
   assign shoot_cnt = sc;
endmodule : spc_motor_model

// ==== verification/tb_spc_top.sv ====
// Self-checking bench of the sine PWM commutation controller
`timescale 1ns/1ns
`include "spc_cfg.svh"
module tb_spc_top;
   // ----------------------------------------
   // Scaled counts keep the run short
   // ----------------------------------------
   localparam int REF_DIV = 2;
   localparam int LOCK_DIV = 4;
   localparam int SLOW_LIM = 200;
   localparam int CAR = REF_DIV * `SPC_CAR_PERIOD;
   localparam int LOCKP = LOCK_DIV * `SPC_LOCK_CYCLES;
   logic pclk = 0;
   logic presetn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic hu, hv, hw, fg;
   logic cs = 0, ext_rst = 0, spd = 1, vm_ok = 1;
   logic run = 0, ccw = 0, fault = 0;
   logic [15:0] step_cyc = 16'h0064;
   logic [2:0] dh, dl, hl;
   logic fg_l = 0;
   logic [31:0] rd;
   logic er;
   int shoot, n_fail = 0, checked = 0, seed = 8, cyc = 0, on_cnt = 0, fg_cnt = 0, hall_cnt = 0;
   int i, k, o0, f0, h0, d;

   spc_top #(.REF_DIV(REF_DIV), .LOCK_DIV(LOCK_DIV), .SLOW_LIM(SLOW_LIM)) spc_top_i (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .hall_phase_u(hu), .hall_phase_v(hv),
      .hall_phase_w(hw), .current_sense_input(cs), .ext_reset_in(ext_rst), .speed_command_input(spd),
      .motor_supply_ok(vm_ok), .drive_high(dh), .drive_low(dl), .rotation_pulse_out(fg));
   spc_motor_model spc_motor_model_i (.pclk(pclk), .run(run), .ccw(ccw), .fault(fault), .step_cyc(step_cyc),
      .hall_u(hu), .hall_v(hv), .hall_w(hw), .drive_high(dh), .drive_low(dl), .shoot_cnt(shoot));

   // 250 MHz clock
   initial
   begin
      forever #2 pclk = ~pclk;
   end

   // Edge, pulse and drive activity counters; cycle ceiling cuts a hang
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      hl <= {hu, hv, hw};
      fg_l <= fg;
      if ({hu, hv, hw} != hl)
         hall_cnt <= hall_cnt + 1;
      if (fg !== fg_l)
         fg_cnt <= fg_cnt + 1;
      if ((dh | dl) != 3'h0)
         on_cnt <= on_cnt + 1;
      if (cyc == 80000)
      begin
         n_fail++;
         summarize();
      end
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task summarize;
      $display("checks=%0d fails=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize

   // APB transfer; waits for pready, takes data at that edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
         n_fail++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Expected mode, slow and direction bits of the status word
   function logic [31:0] exp_mode(input logic dsel, input logic dccw);
      return {26'h0, dccw, 4'h0, dsel == dccw};
   endfunction : exp_mode

   task wait_edges(input int n);
      h0 = hall_cnt;
      k = 0;
      while (hall_cnt < h0 + n && k < 8000)
      begin
         @(posedge pclk);
         k++;
      end
      repeat (5) @(posedge pclk);
   endtask : wait_edges

   task lock_state(input logic [31:0] exp);
      apb(1'b0, `SPC_STAT_OFS, 32'h0000_0000);
      check(32'(rd[7:6]), exp);
   endtask : lock_state

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (8) @(posedge pclk);
      check({26'h0, dh, dl}, 32'h0000_0000);
      presetn <= 1'b1;
      // Lead codes: both ends and random ones read back
      for (i = 0; i < 4; i++)
      begin
         d = (i == 0) ? 0 : (i == 1) ? 31 : ($random(seed) & 31);
         apb(1'b1, `SPC_CTRL_OFS, 32'(d << 2));
         apb(1'b0, `SPC_CTRL_OFS, 32'h0000_0000);
         check(rd, 32'(d << 2));
      end
      apb(1'b0, 12'h00C, 32'h0000_0000);
      check({31'h0, er}, 32'h0000_0001);
      check(rd, 32'h0000_0000);
      // Every pairing of select and actual direction, random pace
      for (i = 0; i < 4; i++)
      begin
         apb(1'b1, `SPC_CTRL_OFS, {31'h0, i[1]});
         ccw <= i[0];
         step_cyc <= 16'(60 + ($random(seed) & 63));
         run <= 1'b1;
         wait_edges(12);
         f0 = fg_cnt;
         wait_edges(6);
         check(32'(fg_cnt - f0), 32'h0000_0006);
         apb(1'b0, `SPC_STAT_OFS, 32'h0000_0000);
         check(rd & 32'h0000_0023, exp_mode(i[1], i[0]));
         apb(1'b0, `SPC_PER_OFS, 32'h0000_0000);
         d = int'(rd) - int'(step_cyc) / REF_DIV;
         check(32'(d <= 2 && d >= -2), 32'h0000_0001);
      end
      o0 = on_cnt;
      repeat (CAR) @(posedge pclk);
      check(32'(on_cnt > o0), 32'h0000_0001);
      // Each shutdown cause except lock: nothing driven, then drive resumes
      for (i = 0; i < 5; i++)
      begin
         ext_rst <= (i == 0);
         spd <= (i != 1);
         vm_ok <= (i != 2);
         cs <= (i == 3);
         fault <= (i == 4);
         repeat (3) @(posedge pclk);
         o0 = on_cnt;
         repeat (CAR + 10) @(posedge pclk);
         check(32'(on_cnt == o0), 32'h0000_0001);
         apb(1'b0, `SPC_STAT_OFS, 32'h0000_0000);
         check(32'(rd[4]), 32'h0000_0001);
         if (i >= 3)
            check(32'(rd[i - 1]), 32'h0000_0001);
         {ext_rst, spd, vm_ok, cs, fault} <= 5'b0_1100;
         wait_edges(12);
         o0 = on_cnt;
         repeat (2 * CAR) @(posedge pclk);
         check(32'(on_cnt > o0), 32'h0000_0001);
      end
      check(32'(shoot), 32'h0000_0000);
      // Stall with latching restart, then clear by stop command
      run <= 1'b0;
      apb(1'b1, `SPC_CTRL_OFS, 32'h0000_0001);
      repeat (SLOW_LIM * REF_DIV + LOCKP + 600) @(posedge pclk);
      apb(1'b0, `SPC_STAT_OFS, 32'h0000_0000);
      check(rd & 32'h0000_00C3, 32'h0000_00C2);
      o0 = on_cnt;
      repeat (CAR) @(posedge pclk);
      check(32'(on_cnt == o0), 32'h0000_0001);
      spd <= 1'b0;
      repeat (4) @(posedge pclk);
      spd <= 1'b1;
      lock_state(32'h0000_0000);
      // Automatic restart alternates off and on, one lock period each
      apb(1'b1, `SPC_CTRL_OFS, 32'h0000_0003);
      repeat (LOCKP + 700) @(posedge pclk);
      lock_state(32'h0000_0001);
      repeat (LOCKP - 20) @(posedge pclk);
      lock_state(32'h0000_0002);
      repeat (LOCKP - 20) @(posedge pclk);
      lock_state(32'h0000_0001);
      // Motor turns again: protection cancelled once 180 mode returns
      run <= 1'b1;
      repeat (LOCKP) @(posedge pclk); // Off period may still be running; it ignores the mode
      wait_edges(30);
      apb(1'b0, `SPC_STAT_OFS, 32'h0000_0000);
      check(rd & 32'h0000_00C3, 32'h0000_0001);
      summarize();
   end
endmodule : tb_spc_top
